/* test/acsw_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module acsw_core_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic modify_req,
    input wire logic [31:0] modify_old,
    input wire acsw_pkg::acsw_cmp_s cmp,
    input wire acsw_pkg::acsw_cls_s cls,
    input wire acsw_pkg::acsw_exc_s exc,
    input wire logic handler_entry,
    input wire logic handler_return,
    input wire logic [31:0] save_word,
    input wire logic save_valid,
    input wire logic [31:0] acsw_word,
    input wire acsw_pkg::acsw_ctl_s ctl,
    input wire acsw_pkg::acsw_fault_s fault,
    input wire logic allow_imprecise
);
    import acsw_pkg::*;
    localparam logic [31:0] STICKY_BITS = 32'h001F0100;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_saved;
        save_valid && save_word == $past(acsw_word);
    endsequence
    a_save_entry: assert property (handler_entry |=> s_saved)
        else $error("save record mismatch");
    // modify and restore may clear flags on purpose, so only quiet cycles count
    a_sticky_hold: assert property (!modify_req && !handler_return |=>
        (acsw_word & $past(acsw_word) & STICKY_BITS) == ($past(acsw_word) & STICKY_BITS))
        else $error("sticky flag dropped");
    a_cc_hold: assert property (cmp.kind == ACSW_CMP_NONE && !modify_req &&
        !handler_return |=> $stable(acsw_word[2:0])) else $error("condition code moved");
    a_bool_code: assert property (cmp.kind == ACSW_CMP_BOOL && !handler_return |=>
        acsw_word[2:0] == ($past(cmp.bool_val) ? CC_TRUE : CC_FALSE)) else $error("bool code");
    a_nan_unord: assert property (cmp.kind == ACSW_CMP_FP && (cmp.a_nan || cmp.b_nan) &&
        !handler_return |=> acsw_word[2:0] == CC_UNORD) else $error("nan not unordered");
    a_class_field: assert property (cls.valid && !handler_return |=>
        acsw_word[6:3] == $past({cls.sign, cls.cls})) else $error("class field wrong");
    a_old_word: assert property (modify_req && !handler_return |=>
        modify_old == $past(acsw_word)) else $error("old word wrong");
    a_decode_out: assert property (fault == {exc.int_ovf & ~acsw_word[12],
        exc.fp_exc & ~acsw_word[28:24], exc.fp_denorm_op & ~acsw_word[29]} &&
        allow_imprecise == !acsw_word[15] && ctl.rnd == acsw_word[31:30])
        else $error("decoded outputs wrong");
endmodule
bind acsw_core acsw_core_checker i_chk (.*);
`default_nettype wire

/* test/arith_control_status_word_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module arith_control_status_word_tb;
    import acsw_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n, modify_req, handler_entry, handler_return;
    logic [31:0] modify_mask, modify_src, record_word, modify_old, save_word, acsw_word, w, o, g;
    acsw_cmp_s cmp;
    acsw_cls_s cls;
    acsw_exc_s exc;
    logic [15:0] seed_q = 16'hDF0B;
    logic [33:0] q[$];
    logic [33:0] n;
    int error_cnt = 0;
    int cmp_count = 0;
    always #50 ref_clk = ~ref_clk;
    acsw_core i_dut (.ref_clk, .rst_n, .modify_req, .modify_mask, .modify_src, .modify_old,
        .cmp, .cls, .exc, .handler_entry, .handler_return, .record_word, .save_word,
        .save_valid(), .acsw_word, .ctl(), .fault(), .allow_imprecise());
    function automatic logic [31:0] rnd32();
        logic [31:0] r;
        repeat (2) begin
            seed_q = {seed_q[14:0], seed_q[15] ^ seed_q[13] ^ seed_q[12] ^ seed_q[10]};
            r = {r[15:0], seed_q};
        end
        return r;
    endfunction
    // the word is noted only after the taking edge, so the monitor never looks early
    task automatic go();
        @(posedge ref_clk);
        {modify_req, handler_entry, handler_return, cmp, cls, exc} <= '0;
        q.push_back({2'h0, w});
    endtask
    task automatic mod(input logic [31:0] m, input logic [31:0] s);
        @(posedge ref_clk);
        modify_req <= 1'b1;
        modify_mask <= m;
        modify_src <= s;
        o = w;
        w = ((w & ~m) | (s & m)) & ACSW_IMPL;
        go();
        q.push_back({2'h1, o});
    endtask
    always @(negedge ref_clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            g = n[33] ? save_word : (n[32] ? modify_old : acsw_word);
            cmp_count++;
            if (g !== n[31:0]) begin
                error_cnt++;
                $display("unexpected word %0d expected %h seen %h", n[33:32], n[31:0], g);
            end
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        {modify_req, handler_entry, handler_return, modify_mask, modify_src, record_word} = '0;
        {cmp, cls, exc} = '0;
        w = ACSW_RESET;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        go();
        mod(32'hFFFFFFFF, 32'hFFFFFFFF);
        mod(32'h00000000, rnd32());
        repeat (6) mod(rnd32(), rnd32());
        for (int i = 0; i < 4; i++) mod(32'hC0000000, {i[1:0], 30'h0});
        $display("modify test done");
        mod(32'h3F1F9100, 32'h00008000);
        @(posedge ref_clk);
        exc <= {1'b1, 5'h1F, 1'b1};
        go();
        mod(32'h1F001000, 32'h15001000);
        @(posedge ref_clk);
        exc <= {1'b1, 5'h1F, 1'b0};
        w = w | 32'h00150100;
        go();
        $display("fault test done");
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            cmp <= {ACSW_CMP_INT, 1'b0, i[2:0], 2'h0};
            w[2:0] = i[2:0];
            go();
            @(posedge ref_clk);
            cmp <= {i[0] ? ACSW_CMP_BOOL : ACSW_CMP_FP, i[1], 3'h5, i[2], 1'b0};
            w[2:0] = i[0] ? (i[1] ? CC_TRUE : CC_FALSE) : (i[2] ? CC_UNORD : CC_LT | CC_GT);
            go();
        end
        $display("compare test done");
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            cls <= {1'b1, i[0], i[2:0]};
            w[6:3] = {i[0], i[2:0]};
            go();
        end
        $display("class test done");
        @(posedge ref_clk);
        handler_entry <= 1'b1;
        o = w;
        go();
        q.push_back({2'h2, o});
        @(posedge ref_clk);
        handler_return <= 1'b1;
        modify_req <= 1'b1;
        o = rnd32();
        record_word <= o;
        w = o & ACSW_IMPL;
        go();
        $display("handler test done");
        repeat (2) @(posedge ref_clk);
        wrap_up();
    end
endmodule
`default_nettype wire

/* verilog/acsw_core.sv */
`timescale 1ns/1ps
`default_nettype none
module acsw_core (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic modify_req,
    input wire logic [31:0] modify_mask,
    input wire logic [31:0] modify_src,
    output logic [31:0] modify_old,
    input wire acsw_pkg::acsw_cmp_s cmp,
    input wire acsw_pkg::acsw_cls_s cls,
    input wire acsw_pkg::acsw_exc_s exc,
    input wire logic handler_entry,
    input wire logic handler_return,
    input wire logic [31:0] record_word,
    output logic [31:0] save_word,
    output logic save_valid,
    output logic [31:0] acsw_word,
    output acsw_pkg::acsw_ctl_s ctl,
    output acsw_pkg::acsw_fault_s fault,
    output logic allow_imprecise
);
    import acsw_pkg::*;

    logic [31:0] word_q;
    logic [31:0] word_d;
    logic [31:0] old_q;
    logic [31:0] old_d;
    logic [31:0] save_q;
    logic [31:0] save_d;
    logic save_valid_q;
    logic save_valid_d;
    logic [31:0] sticky_set;
    logic [2:0] cc_new;
    logic cc_write;
    logic [31:0] merged;

    acsw_fault u_fault (
        .exc(exc),
        .iov_mask(word_q[IOV_MASK]),
        .fp_mask(word_q[FP_MASK_LSB +: FP_N]),
        .norm_mode(word_q[NORM_MODE]),
        .fault(fault),
        .sticky_set(sticky_set)
    );

    // condition code from the instruction result
    always_comb begin
        cc_new = word_q[CC_LSB +: CC_W];
        cc_write = 1'b0;
        case (cmp.kind)
            ACSW_CMP_BOOL: begin
                cc_write = 1'b1;
                cc_new = cmp.bool_val ? CC_TRUE : CC_FALSE;
            end
            ACSW_CMP_INT: begin
                cc_write = 1'b1;
                // each of lt/eq/gt sets one code bit so ge, ne, le come free
                cc_new = {cmp.lt, cmp.eq, cmp.gt};
            end
            ACSW_CMP_FP: begin
                cc_write = 1'b1;
                if (cmp.a_nan | cmp.b_nan) begin
                    cc_new = CC_UNORD;
                end else begin
                    cc_new = {cmp.lt, cmp.eq, cmp.gt};
                end
            end
            default: begin
                cc_write = 1'b0;
            end
        endcase
    end

    // word update; priority: handler return, then hardware events, then modify
    always_comb begin
        word_d = word_q;
        old_d = old_q;
        save_d = save_q;
        save_valid_d = 1'b0;
        merged = (word_q & ~modify_mask) | (modify_src & modify_mask);
        if (handler_entry) begin
            save_d = word_q;
            save_valid_d = 1'b1;
        end
        if (handler_return) begin
            word_d = record_word & ACSW_IMPL;
        end else begin
            if (modify_req) begin
                old_d = word_q;
                word_d = merged & ACSW_IMPL;
            end
            if (cc_write) begin
                word_d[CC_LSB +: CC_W] = cc_new;
            end
            if (cls.valid) begin
                word_d[CLS_LSB +: CLS_W] = cls.cls;
                word_d[CLS_SIGN] = cls.sign;
            end
            // hardware only ORs flags in; the set wins over a program clear
            word_d = word_d | sticky_set;
        end
        if (!rst_n) begin
            // architecturally undefined after reset; zero keeps sim clean
            word_d = ACSW_RESET;
            old_d = ACSW_RESET;
            save_d = ACSW_RESET;
            save_valid_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        word_q <= word_d;
        old_q <= old_d;
        save_q <= save_d;
        save_valid_q <= save_valid_d;
    end

    always_comb begin
        acsw_word = word_q;
        modify_old = old_q;
        save_word = save_q;
        save_valid = save_valid_q;
        ctl.cc = word_q[CC_LSB +: CC_W];
        ctl.iov_mask = word_q[IOV_MASK];
        ctl.fp_mask = word_q[FP_MASK_LSB +: FP_N];
        ctl.precise = word_q[NO_IMPRECISE];
        ctl.norm_mode = word_q[NORM_MODE];
        ctl.rnd = acsw_rnd_e'(word_q[RND_LSB +: RND_W]);
        allow_imprecise = ~word_q[NO_IMPRECISE];
    end
endmodule
`default_nettype wire

/* verilog/acsw_fault.sv */
`timescale 1ns/1ps
`default_nettype none
module acsw_fault (
    input wire acsw_pkg::acsw_exc_s exc,
    input wire logic iov_mask,
    input wire logic [4:0] fp_mask,
    input wire logic norm_mode,
    output acsw_pkg::acsw_fault_s fault,
    output logic [31:0] sticky_set
);
    import acsw_pkg::*;

    // per-bit results gathered here so each output has a single driver
    logic [4:0] fp_fault;
    logic [4:0] fp_set;

    genvar i;
    generate
        for (i = 0; i < FP_N; i++) begin : g_fp
            assign fp_fault[i] = exc.fp_exc[i] & ~fp_mask[i];
            assign fp_set[i] = exc.fp_exc[i] & fp_mask[i];
        end
    endgenerate

    always_comb begin
        sticky_set = '0;
        // masked overflow records a flag, unmasked one faults and leaves flag
        sticky_set[IOV_FLAG] = exc.int_ovf & iov_mask;
        sticky_set[FP_FLAG_LSB +: FP_N] = fp_set;
        fault.int_ovf = exc.int_ovf & ~iov_mask;
        fault.fp_exc = fp_fault;
        // a denormal outside normalizing mode is a reserved-operand fault
        fault.fp_resop = exc.fp_denorm_op & ~norm_mode;
    end
endmodule
`default_nettype wire

/* verilog/acsw_pkg.sv */
package acsw_pkg;
    localparam int ACSW_W = 32;
    // field positions inside the arithmetic-controls word
    localparam int CC_LSB = 0;
    localparam int CC_W = 3;
    localparam int CLS_LSB = 3;
    localparam int CLS_W = 3;
    localparam int CLS_SIGN = 6;
    localparam int IOV_FLAG = 8;
    localparam int IOV_MASK = 12;
    localparam int NO_IMPRECISE = 15;
    localparam int FP_FLAG_LSB = 16;
    localparam int FP_MASK_LSB = 24;
    localparam int FP_N = 5;
    localparam int NORM_MODE = 29;
    localparam int RND_LSB = 30;
    localparam int RND_W = 2;
    // bits that hold state; all others are reserved and read as zero
    localparam logic [31:0] ACSW_IMPL = 32'hFF1F917F;
    localparam logic [31:0] ACSW_RESET = 32'h00000000;

    localparam logic [2:0] CC_FALSE = 3'h0;
    localparam logic [2:0] CC_TRUE = 3'h2;
    localparam logic [2:0] CC_UNORD = 3'h0;
    localparam logic [2:0] CC_GT = 3'h1;
    localparam logic [2:0] CC_EQ = 3'h2;
    localparam logic [2:0] CC_LT = 3'h4;
    localparam logic [2:0] CC_ORD = 3'h7;

    typedef enum logic [2:0] {
        ACSW_CLS_ZERO = 3'h0,
        ACSW_CLS_DENORM = 3'h1,
        ACSW_CLS_NORMAL = 3'h2,
        ACSW_CLS_INF = 3'h3,
        ACSW_CLS_QNAN = 3'h4,
        ACSW_CLS_SNAN = 3'h5,
        ACSW_CLS_RESOP = 3'h6
    } acsw_class_e;

    typedef enum logic [1:0] {
        ACSW_RND_NEAREST = 2'h0,
        ACSW_RND_DOWN = 2'h1,
        ACSW_RND_UP = 2'h2,
        ACSW_RND_ZERO = 2'h3
    } acsw_rnd_e;

    typedef enum logic [2:0] {
        ACSW_CMP_NONE = 3'h0,
        ACSW_CMP_BOOL = 3'h1,
        ACSW_CMP_INT = 3'h2,
        ACSW_CMP_FP = 3'h4
    } acsw_cmp_e;

    // condition-code producing instruction result
    typedef struct packed {
        acsw_cmp_e kind;
        logic bool_val;
        logic lt;
        logic eq;
        logic gt;
        logic a_nan;
        logic b_nan;
    } acsw_cmp_s;

    // classify instruction result
    typedef struct packed {
        logic valid;
        logic sign;
        acsw_class_e cls;
    } acsw_cls_s;

    // arithmetic exception events
    typedef struct packed {
        logic int_ovf;
        logic [4:0] fp_exc;
        logic fp_denorm_op;
    } acsw_exc_s;

    // decoded control view of the word
    typedef struct packed {
        acsw_rnd_e rnd;
        logic norm_mode;
        logic precise;
        logic [4:0] fp_mask;
        logic iov_mask;
        logic [2:0] cc;
    } acsw_ctl_s;

    // fault requests raised for unmasked conditions
    typedef struct packed {
        logic int_ovf;
        logic [4:0] fp_exc;
        logic fp_resop;
    } acsw_fault_s;
endpackage
